// ---- rtl/ufb_bridge_pwm.sv ----
// Notes on behaviour
// - the fast leg pair is pulse-width modulated at switching rate in both half cycles.
// - the slow leg pair changes only when the latched polarity changes just after a carrier peak, or when enable falls or rises.
// - positive half holds slow lower on, fast leg toggles between bus level and zero.
// - negative half holds slow upper on, fast leg toggles between minus bus and zero.
// - the up-down carrier gives a 20 kHz switching frequency.
// - updates land at carrier peaks so each pulse is centred and zero crossings symmetric.
`timescale 1ns/1ns
module ufb_bridge_pwm #(
    parameter int PERIOD = ufb_pkg::PERIOD_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clockEnable,
    input wire logic enable,
    input wire logic commandPositive,
    input wire logic [ufb_pkg::CNT_W-1:0] commandDuty,
    input wire logic [ufb_pkg::DEAD_W-1:0] deadTimeCycles,
    output ufb_pkg::ufb_gates_t gates,
    output logic periodStart
);
    localparam logic [ufb_pkg::CNT_W-1:0] HALF = ufb_pkg::CNT_W'(PERIOD / 2);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // cap a duty request at the half period; anything larger would leave
    // the fast leg with no off window and hide the peak from the compare
    function automatic logic [ufb_pkg::CNT_W-1:0] clampDuty(
        input logic [ufb_pkg::CNT_W-1:0] request,
        input logic [ufb_pkg::CNT_W-1:0] limit
    );
        clampDuty = (request > limit) ? limit : request;
    endfunction

    // a leg is safe while at most one of its two switches is on
    function automatic logic legSafe(
        input logic upper,
        input logic lower
    );
        legSafe = !(upper && lower);
    endfunction

    ufb_pkg::ufb_state_t state;
    ufb_pkg::ufb_state_t next_state;
    logic atPeak;
    logic fastOn;

    // ------------------------------------------------------------
    // carrier, sampling and gate logic
    // ------------------------------------------------------------
    // the direction bit flips on the same edge that reaches either end, so the
    // ends are recognised by the count alone; testing the direction as well
    // could never match and no command would ever be taken
    assign atPeak = (state.carrier == HALF);
    assign periodStart = (state.carrier == ufb_pkg::CNT_ZERO);
    assign gates = state.gates;

    // carrier: 0 up to HALF and back to 0, so one switching period is
    // 2*HALF clocks; an odd PERIOD loses one clock to the halving
    // commands are taken only at the peak, which costs up to a period of
    // latency but keeps every fast pulse centred on the trough
    // the slow pair follows the latched polarity, never the raw input,
    // so a noisy polarity command cannot chatter the low-frequency leg

    always_comb begin
        next_state = state;
        // triangular carrier, HALF up and HALF down
        if (state.countDown) begin
            if (state.carrier == ufb_pkg::CNT_ONE) begin
                next_state.countDown = 1'b0;
            end
            next_state.carrier = state.carrier - ufb_pkg::CNT_ONE;
        end else begin
            if (state.carrier == HALF - ufb_pkg::CNT_ONE) begin
                next_state.countDown = 1'b1;
            end
            next_state.carrier = state.carrier + ufb_pkg::CNT_ONE;
        end
        // latch command at the peak only: pulses stay centred on the trough,
        // so a polarity swap lands mid-off-time and both sides mirror
        if (atPeak) begin
            next_state.duty = clampDuty(commandDuty, HALF);
            next_state.positiveHalf = commandPositive;
            next_state.deadTime = deadTimeCycles;
        end
        // compare: positive half wants fast upper on for the duty window
        fastOn = state.carrier < state.duty;
        next_state.fastWant = state.positiveHalf ? fastOn : !fastOn;
        // dead time: on any demand change both fast gates drop first
        if (next_state.fastWant != state.fastWant) begin
            next_state.deadCount = state.deadTime;
            next_state.gates.fastUpper = 1'b0;
            next_state.gates.fastLower = 1'b0;
        end else if (state.deadCount != ufb_pkg::DEAD_ZERO) begin
            next_state.deadCount = state.deadCount - ufb_pkg::DEAD_ONE;
        end else begin
            next_state.gates.fastUpper = state.fastWant;
            next_state.gates.fastLower = !state.fastWant;
        end
        // slow leg follows polarity, break-before-make through a both-off cycle
        if (state.gates.slowLower != state.positiveHalf
                || state.gates.slowUpper == state.positiveHalf) begin
            if (state.gates.slowLower || state.gates.slowUpper) begin
                next_state.gates.slowLower = 1'b0;
                next_state.gates.slowUpper = 1'b0;
            end else begin
                next_state.gates.slowLower = state.positiveHalf;
                next_state.gates.slowUpper = !state.positiveHalf;
            end
        end
        // disabled bridge: all gates off, carrier keeps running
        if (!enable) begin
            next_state.gates = '0;
            next_state.deadCount = state.deadTime;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset loads the long default dead time into the counter as well, so
    // the first turn-on after enable waits out a full gap even if the
    // control side never programs one
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
            state.deadTime <= ufb_pkg::DEAD_RESET;
            state.deadCount <= ufb_pkg::DEAD_RESET;
        end else if (clockEnable) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // slow-leg polarity checks allow the one cycle after a polarity swap,
    // in which the old switch is still on while the break is being made
    AST_FAST_SHOOT: assert property (@(posedge clock) disable iff (!rstn)
        legSafe(gates.fastUpper, gates.fastLower)) else $error("fast leg shoot-through");
    AST_SLOW_SHOOT: assert property (@(posedge clock) disable iff (!rstn)
        legSafe(gates.slowUpper, gates.slowLower)) else $error("slow leg shoot-through");
    AST_POS_HALF: assert property (@(posedge clock) disable iff (!rstn)
        gates.slowLower |-> !gates.slowUpper && (state.positiveHalf || $past(state.positiveHalf)))
        else $error("slow lower on outside positive half");
    AST_NEG_HALF: assert property (@(posedge clock) disable iff (!rstn)
        gates.slowUpper |-> !state.positiveHalf || !$past(state.positiveHalf))
        else $error("slow upper on in positive half");
    AST_SLOW_STATIC: assert property (@(posedge clock) disable iff (!rstn)
        clockEnable && $changed(state.positiveHalf) |-> $past(atPeak))
        else $error("polarity changed away from carrier peak");
    AST_PERIOD: assert property (@(posedge clock) disable iff (!rstn)
        clockEnable && atPeak |=> !atPeak) else $error("carrier stuck at peak");
    AST_DEAD: assert property (@(posedge clock) disable iff (!rstn)
        $fell(gates.fastLower) |-> !gates.fastUpper) else $error("no break before make");
    AST_CENTRE: assert property (@(posedge clock) disable iff (!rstn)
        clockEnable && atPeak |=> state.countDown) else $error("carrier did not turn at peak");

    AST_DUTY_CLAMP: assert property (@(posedge clock) disable iff (!rstn)
        state.duty <= HALF)
        else $error("duty beyond half period");

    AST_CARRIER_RANGE: assert property (@(posedge clock) disable iff (!rstn)
        state.carrier <= HALF)
        else $error("carrier beyond peak");

    AST_START_ONCE: assert property (@(posedge clock) disable iff (!rstn)
        clockEnable && periodStart |=> !periodStart)
        else $error("period marker longer than one clock");

    AST_TROUGH_TURN: assert property (@(posedge clock) disable iff (!rstn)
        clockEnable && periodStart |=> !state.countDown && state.carrier == ufb_pkg::CNT_ONE)
        else $error("carrier did not turn at trough");

    AST_DISABLED_OFF: assert property (@(posedge clock) disable iff (!rstn)
        clockEnable && !enable |=> gates == '0)
        else $error("gates on while disabled");

    AST_UPPER_GAP: assert property (@(posedge clock) disable iff (!rstn)
        $rose(gates.fastUpper) |-> !$past(gates.fastLower))
        else $error("fast upper made without a gap");

    AST_LOWER_GAP: assert property (@(posedge clock) disable iff (!rstn)
        $rose(gates.fastLower) |-> !$past(gates.fastUpper))
        else $error("fast lower made without a gap");

    AST_SLOW_UPPER_GAP: assert property (@(posedge clock) disable iff (!rstn)
        $rose(gates.slowUpper) |-> !$past(gates.slowLower))
        else $error("slow upper made without a gap");

    AST_SLOW_LOWER_GAP: assert property (@(posedge clock) disable iff (!rstn)
        $rose(gates.slowLower) |-> !$past(gates.slowUpper))
        else $error("slow lower made without a gap");

    // ------------------------------------------------------------
    // usage limits
    // ------------------------------------------------------------
    // the dead time is taken at the peak together with duty and polarity;
    // a gap already being timed keeps its old length until it ends
    // a gap longer than the shortest on or off window swallows that window,
    // so narrow pulses vanish instead of shrinking below the gap
    // duty is counted in clocks on each side of the trough, so the fast
    // upper pulse in the positive half lasts about twice the duty value
    // a zero duty keeps the fast pair parked on its zero-voltage switch
    // and a duty at the half period leaves only the gap at the peak
    // the negative half inverts the compare, so the same duty value gives
    // the same output magnitude with the fast lower switch doing the work
    // the slow pair changes one period at most after the polarity input,
    // and always passes one cycle with both switches off on the way
    // enable low drops all four gates on the next clock and reloads the
    // dead counter, so re-enabling always starts from a full gap
    // the carrier keeps running while disabled so the period marker
    // stays usable for a sampling scheduler that watches it
    // clock enable freezes carrier, counters and gates alike; holding it
    // low mid-pulse stretches that pulse by the frozen time
    // commands may change on any clock; between peaks they are ignored
    // and the last latched values keep running unchanged
    // the period marker is combinational from the carrier register and
    // stands for exactly one clock per switching period
    // the default period gives 20 kHz only at the 250 MHz system clock;
    // another clock needs a matching PERIOD override
    // the gate outputs are registered, so each is glitch-free at the pin
    // and can feed a driver directly without another flip-flop
endmodule // ufb_bridge_pwm

// ---- include/ufb_pkg.sv ----
package ufb_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int SWITCH_HZ = 20_000;
    // up-down carrier: one period spans two ramps
    localparam int PERIOD_CYCLES = CLK_HZ / SWITCH_HZ;
    localparam int HALF_PERIOD = PERIOD_CYCLES / 2;
    localparam int CNT_W = 16;
    localparam int DEAD_W = 8;
    localparam logic [DEAD_W-1:0] DEAD_RESET = 8'h19;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DEAD_W-1:0] DEAD_ZERO = 8'h00;
    localparam logic [DEAD_W-1:0] DEAD_ONE = 8'h01;

    // ------------------------------------------------------------
    // gate carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic fastUpper;
        logic fastLower;
        logic slowUpper;
        logic slowLower;
    } ufb_gates_t;

    typedef struct packed {
        logic [CNT_W-1:0] carrier;
        logic countDown;
        logic positiveHalf;
        logic [CNT_W-1:0] duty;
        logic fastWant;
        logic [DEAD_W-1:0] deadCount;
        logic [DEAD_W-1:0] deadTime;
        ufb_gates_t gates;
    } ufb_state_t;
endpackage

// ---- sim/ufb_gate_model.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// gate driver model
// ------------------------------------------------------------
module ufb_gate_model (
    input wire logic clock,
    input wire logic rstn,
    input ufb_pkg::ufb_gates_t gates,
    output int faults
);
    // a driver pair shorts the bus if both gates of a leg are on
    initial faults = 0;
    always @(posedge clock) begin
        if (rstn && ((gates.fastUpper && gates.fastLower) ||
                     (gates.slowUpper && gates.slowLower))) begin
            faults++;
        end
    end
endmodule // ufb_gate_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic enable = 1'b0;
    logic commandPositive = 1'b1;
    logic [ufb_pkg::CNT_W-1:0] commandDuty = 16'h000A;
    logic [ufb_pkg::DEAD_W-1:0] deadTimeCycles = 8'h02;
    ufb_pkg::ufb_gates_t gates;
    logic periodStart;
    int faults;
    int bad_count = 0;
    int compares = 0;
    int len, upEdges, loEdges, slowEdges, offCycles;
    // short carrier of 40 cycles keeps the run brief
    ufb_bridge_pwm #(.PERIOD(40)) i_ufb_bridge_pwm (.clock(clock), .rstn(rstn),
        .clockEnable(1'b1), .enable(enable), .commandPositive(commandPositive),
        .commandDuty(commandDuty), .deadTimeCycles(deadTimeCycles), .gates(gates),
        .periodStart(periodStart));
    ufb_gate_model i_ufb_gate_model (.clock(clock), .rstn(rstn), .gates(gates), .faults(faults));
    initial forever #2 clock = ~clock;
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task stop_test;
        $display("bad_count %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // counts gate edges over one carrier period, bounded so a dead carrier ends the run
    task measure;
        ufb_pkg::ufb_gates_t prev;
        int n;
        n = 0; len = 0; upEdges = 0; loEdges = 0; slowEdges = 0;
        offCycles = 0;
        do begin @(negedge clock); n++; end while (periodStart !== 1'b1 && n < 200);
        prev = gates;
        do begin
            @(negedge clock);
            len++;
            upEdges += int'(gates.fastUpper & ~prev.fastUpper);
            loEdges += int'(gates.fastLower & ~prev.fastLower);
            slowEdges += int'(gates.slowUpper != prev.slowUpper);
            offCycles += int'(!gates.fastUpper && !gates.fastLower);
            prev = gates;
        end while (periodStart !== 1'b1 && len < 200);
        if (n >= 200 || len >= 200) begin check("wait", 0, 1); stop_test(); end
    endtask
    // commands settle at a peak, so three measures, about six periods, pass before judging
    task run(logic pos, logic [15:0] duty);
        commandPositive = pos;
        commandDuty = duty;
        repeat (3) measure();
    endtask
    task scn_positive;
        run(1'b1, 16'h000A);
        check("period", len, 40);
        check("upEdges", upEdges, 1);
        // two transitions a period, each holds both fast gates off dead time plus one
        check("offCycles", offCycles, 6);
        check("slowEdges", slowEdges, 0);
        check("slowLower", gates.slowLower, 1);
        check("slowUpper", gates.slowUpper, 0);
        run(1'b1, 16'h0000);
        check("upEdgesZero", upEdges, 0);
    endtask
    task scn_negative;
        run(1'b0, 16'h000A);
        check("loEdges", loEdges, 1);
        check("slowUpper", gates.slowUpper, 1);
        check("slowLower", gates.slowLower, 0);
        run(1'b0, 16'h0000);
        check("loEdgesZero", loEdges, 0);
        check("slowEdges", slowEdges, 0);
    endtask
    task scn_disable;
        enable = 1'b0;
        run(1'b1, 16'h000A);
        check("gatesOff", gates, 4'h0);
    endtask
    initial begin
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        enable = 1'b1;
        scn_positive();
        scn_negative();
        scn_disable();
        check("faults", faults, 0);
        stop_test();
    end
endmodule // testbench
